// [programmable_protection_stage.sv]
// bank of eight programmable protection stages with an ahb-lite slave
// Contract
// R1 - eight stages, each enabled or disabled
// R2 - selectable interval, 10 ms for fast stages
// R3 - 20 ms and 100 ms intervals available
// R4 - first selector feeds over, under, difference
// R5 - second selector only for difference modes
// R6 - four modes: over, under, diff, magnitude gap
// R7 - compare against per-unit pickup limit
// R8 - report pickup scaled to primary level
// R9 - trip after definite delay of start
// R10 - under mode ignores values below floor
// R11 - selectable measured and virtual analog signals
// R12 - four setting groups, selectable source
// R13 - group sources: none, di, vi, led, vo, fkey
// R14 - status blocked/start/trip, writable under force
// R15 - shared force flag, clears after 5 minutes
// R16 - release only past dead band
// R17 - start and trip counters, software clearable
`timescale 1ns/100ps
`include "stage_defs.svh"
module programmable_protection_stage #(
  parameter int BASE_CYCLES = `BASE_CYCLES,
  parameter int FORCE_TICKS = `FORCE_TICKS
) (
  input  logic                          sys_clk,
  input  logic                          rst,
  input  logic                          hsel,
  input  logic [31:0]                   haddr,
  input  logic [1:0]                    htrans,
  input  logic                          hwrite,
  input  logic [2:0]                    hsize,
  input  logic [31:0]                   hwdata,
  input  logic                          hready,
  output logic                          hreadyout,
  output logic [31:0]                   hrdata,
  output logic                          hresp,
  input  logic [`NUM_MEAS*`VAL_W-1:0]   meas_value,
  input  logic [`NUM_VAI*`VAL_W-1:0]    virtual_analog_inputs,
  input  logic [7:0]                    digital_input_n,
  input  logic [7:0]                    virtual_input_n,
  input  logic [7:0]                    indicator_signal_n,
  input  logic [7:0]                    virtual_output_n,
  input  logic [7:0]                    function_key_n,
  output logic [`NUM_STAGES-1:0]        stage_start,
  output logic [`NUM_STAGES-1:0]        stage_trip,
  output logic                          force_active,
  output logic                          irq
);
  localparam int NS = `NUM_STAGES;

  logic                      tick_base, tick_mid, tick_slow;
  logic [31:0]               rdata_a, rdata_b, rd_val;
  logic [`MEM_AW-1:0]        rd_addr_b;
  logic                      acc, wr;
  logic [2:0]                ws, rs;
  // bus phase state
  logic                      ph_valid_r, ph_valid_nxt, ph_write_r;
  logic                      ph_write_nxt, ph_mem_r, ph_mem_nxt;
  logic [12:0]               ph_addr_r, ph_addr_nxt;
  logic                      hready_nxt, hresp_nxt;
  logic [31:0]               hrdata_nxt;
  // evaluation engine state
  stage_pkg::eng_state_t     st_r, st_nxt;
  logic [2:0]                stg_r, stg_nxt, wc_r, wc_nxt;
  logic [31:0]               w_r [4], w_nxt [4];
  logic [NS-1:0]             due_r, due_nxt;
  // registers and per-stage state
  logic [NS-1:0]             enable_r, enable_nxt;
  logic                      force_r, force_nxt, irq_nxt;
  logic [15:0]               fcnt_r, fcnt_nxt;
  logic [15:0]               irq_st_r, irq_st_nxt, irq_msk_r, irq_msk_nxt;
  logic [15:0]               ev_set, w1c;
  logic [31:0]               cfg_r [NS], cfg_nxt [NS];
  logic [15:0]               scale_r [NS], scale_nxt [NS];
  logic [15:0]               pick_r [NS], pick_nxt [NS];
  logic [15:0]               scnt_r [NS], scnt_nxt [NS];
  logic [15:0]               tcnt_r [NS], tcnt_nxt [NS];
  logic [19:0]               el_r [NS], el_nxt [NS];
  logic [1:0]                grp_r [NS], grp_nxt [NS];
  logic [NS-1:0]             start_r, start_nxt, trip_r, trip_nxt;
  // comparison results
  stage_pkg::cmp_mode_t      mode;
  logic signed [17:0]        a_x, b_x, diff, q, pk, fl, band;
  logic [17:0]               pk_mag;
  logic [35:0]               prod;
  logic [20:0]               el_sum;
  logic [19:0]               el_new;
  logic                      under, above, hit, rel, st_new, tr_new;
  logic signed [32:0]        prim_prod;

  // selectable supervised quantity, virtual analog inputs at the top
  function automatic logic [15:0] sig_pick(input logic [5:0] sel);
    if (sel < 6'(`NUM_MEAS)) begin
      return meas_value[sel*`VAL_W +: `VAL_W]; // see R11
    end
    return virtual_analog_inputs[(sel - 6'(`NUM_MEAS))*`VAL_W +: `VAL_W];
  endfunction : sig_pick

  // active group from the manual setting or the chosen select signal
  function automatic logic [1:0] grp_sel(input logic [31:0] cfg);
    logic       lvl;
    logic [2:0] i;
    i = cfg[`CFG_SRCI];
    case (stage_pkg::grp_src_t'(cfg[`CFG_SRCK])) // see R13
      stage_pkg::src_digital:   lvl = digital_input_n[i];
      stage_pkg::src_virtual:   lvl = virtual_input_n[i];
      stage_pkg::src_indicator: lvl = indicator_signal_n[i];
      stage_pkg::src_vout:      lvl = virtual_output_n[i];
      stage_pkg::src_fkey:      lvl = function_key_n[i];
      default:                  lvl = 1'b0;
    endcase
    return lvl ? cfg[`CFG_ALTG] : cfg[`CFG_GRP]; // see R12
  endfunction : grp_sel

  // evaluation interval in milliseconds
  function automatic logic [19:0] ival_ms(input logic [1:0] sel);
    case (sel)
      2'h0:    return 20'(`BASE_MS); // see R2
      2'h1:    return 20'(`MID_MS); // see R3
      default: return 20'(`SLOW_MS); // see R3
    endcase
  endfunction : ival_ms

  function automatic logic in_stage(input logic [12:0] a);
    return a[`STG_SEL] == `STG_TAG;
  endfunction : in_stage

  function automatic logic is_mem(input logic [12:0] a);
    return a[`MEM_SEL] == `MEM_TAG;
  endfunction : is_mem

  interval_tick #(.BASE_CYCLES(BASE_CYCLES)) u_tick (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .tick_base (tick_base),
    .tick_mid  (tick_mid),
    .tick_slow (tick_slow)
  );

  setting_mem u_mem (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .wr_en     (wr && is_mem(ph_addr_r)),
    .wr_addr   (ph_addr_r[`MEM_IDX]),
    .wr_data   (hwdata),
    .rd_addr_a (haddr[`MEM_IDX]),
    .rd_data_a (rdata_a),
    .rd_addr_b (rd_addr_b),
    .rd_data_b (rdata_b)
  );

  // address decode helpers
  assign acc       = hsel && htrans[1] && hready;
  assign wr        = ph_valid_r && ph_write_r;
  assign ws        = ph_addr_r[`STG_IDX];
  assign rs        = haddr[`STG_IDX];
  assign rd_addr_b = {stg_r, grp_r[stg_r], wc_r[1:0]};
  assign prim_prod = $signed(pick_r[rs]) * $signed({1'b0, scale_r[rs]});

  // register read mux, sampled in the address phase
  always_comb begin
    rd_val = 32'h0000_0000;
    if (in_stage(haddr[12:0])) begin
      case (haddr[`STG_OFF])
        `O_CFG:    rd_val = cfg_r[rs];
        `O_STATUS: rd_val = {26'h0, grp_r[rs], 1'b0, trip_r[rs],
                             start_r[rs], !enable_r[rs]}; // see R14
        `O_SCNT:   rd_val = {16'h0, scnt_r[rs]};
        `O_TCNT:   rd_val = {16'h0, tcnt_r[rs]};
        `O_PRIM:   rd_val = 32'($signed(prim_prod[`PRIM_BITS])); // see R8
        `O_SCALE:  rd_val = {16'h0, scale_r[rs]};
        default:   rd_val = 32'h0000_0000;
      endcase
    end else begin
      case (haddr[12:0])
        `A_ENABLE:  rd_val = {24'h0, enable_r};
        `A_FORCE:   rd_val = {31'h0, force_r};
        `A_IRQ_ST:  rd_val = {16'h0, irq_st_r};
        `A_IRQ_MSK: rd_val = {16'h0, irq_msk_r};
        default:    rd_val = 32'h0000_0000;
      endcase
    end
  end

  // ahb-lite phases; memory reads take one wait state
  always_comb begin
    ph_valid_nxt = ph_valid_r;
    ph_write_nxt = ph_write_r;
    ph_mem_nxt   = ph_mem_r;
    ph_addr_nxt  = ph_addr_r;
    hready_nxt   = 1'b1;
    hrdata_nxt   = hrdata;
    hresp_nxt    = 1'b0;
    if (hready) begin
      ph_valid_nxt = acc;
      ph_write_nxt = hwrite;
      ph_mem_nxt   = is_mem(haddr[12:0]);
      ph_addr_nxt  = haddr[12:0];
      if (acc && !hwrite) begin
        if (is_mem(haddr[12:0])) begin
          hready_nxt = 1'b0;
        end else begin
          hrdata_nxt = rd_val;
        end
      end
    end else if (ph_valid_r && ph_mem_r && !ph_write_r) begin
      hrdata_nxt = rdata_a;
    end
  end

  // bus registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ph_valid_r <= 1'b0;
      ph_write_r <= 1'b0;
      ph_mem_r   <= 1'b0;
      ph_addr_r  <= 13'h0000;
      hreadyout  <= 1'b1;
      hrdata     <= 32'h0000_0000;
      hresp      <= 1'b0;
    end else begin
      ph_valid_r <= ph_valid_nxt;
      ph_write_r <= ph_write_nxt;
      ph_mem_r   <= ph_mem_nxt;
      ph_addr_r  <= ph_addr_nxt;
      hreadyout  <= hready_nxt;
      hrdata     <= hrdata_nxt;
      hresp      <= hresp_nxt;
    end
  end

  // engine: on each base tick fetch and evaluate every stage in turn
  always_comb begin
    st_nxt  = st_r;
    stg_nxt = stg_r;
    wc_nxt  = wc_r;
    w_nxt   = w_r;
    due_nxt = due_r;
    case (st_r)
      stage_pkg::e_idle: begin
        if (tick_base) begin
          for (int s = 0; s < NS; s++) begin
            case (cfg_r[s][`CFG_IVAL])
              2'h0:    due_nxt[s] = 1'b1; // see R2
              2'h1:    due_nxt[s] = tick_mid; // see R3
              default: due_nxt[s] = tick_slow; // see R3
            endcase
          end
          stg_nxt = 3'h0;
          wc_nxt  = 3'h0;
          st_nxt  = stage_pkg::e_fetch;
        end
      end
      stage_pkg::e_fetch: begin
        if (wc_r != 3'h0) begin
          w_nxt[wc_r[1:0] - 2'h1] = rdata_b;
        end
        if (wc_r == 3'h4) begin
          st_nxt = stage_pkg::e_eval;
        end else begin
          wc_nxt = wc_r + 3'h1;
        end
      end
      stage_pkg::e_eval: begin
        wc_nxt  = 3'h0;
        stg_nxt = stg_r + 3'h1;
        st_nxt  = (stg_r == 3'(NS - 1)) ? stage_pkg::e_idle
                                        : stage_pkg::e_fetch;
      end
      default: st_nxt = stage_pkg::e_idle;
    endcase
  end

  // engine registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r  <= stage_pkg::e_idle;
      stg_r <= 3'h0;
      wc_r  <= 3'h0;
      due_r <= '0;
      for (int k = 0; k < 4; k++) begin
        w_r[k] <= 32'h0000_0000;
      end
    end else begin
      st_r  <= st_nxt;
      stg_r <= stg_nxt;
      wc_r  <= wc_nxt;
      due_r <= due_nxt;
      w_r   <= w_nxt;
    end
  end

  // comparison of the fetched stage against its active group settings
  always_comb begin
    mode   = stage_pkg::cmp_mode_t'(w_r[0][`W0_MODE]); // see R6
    a_x    = 18'($signed(sig_pick(w_r[0][`W0_SELA]))); // see R4
    b_x    = 18'($signed(sig_pick(w_r[0][`W0_SELB]))); // see R5
    diff   = a_x - b_x;
    case (mode)
      stage_pkg::mode_diff:          q = diff; // see R5
      stage_pkg::magnitude_gap_mode: q = diff[17] ? -diff : diff;
      default:                       q = a_x; // see R4
    endcase
    pk     = 18'($signed(w_r[1][`W1_PICK]));
    fl     = 18'($signed(w_r[3][`W3_FLOOR]));
    pk_mag = pk[17] ? 18'(-pk) : 18'(pk);
    prod   = 36'(pk_mag) * 36'(w_r[3][`W3_HYST]) * `HYST_MUL;
    band   = 18'(prod[`BAND_BITS]);
    under  = (mode == stage_pkg::mode_under);
    above  = (q >= fl);
    hit    = under ? ((q < pk) && above) : (q > pk); // see R7, R10
    rel    = under ? ((q > pk + band) || !above)
                   : (q < pk - band); // see R16, R10
    st_new = start_r[stg_r] ? !rel : hit;
    el_sum = 21'(el_r[stg_r]) + 21'(ival_ms(cfg_r[stg_r][`CFG_IVAL]));
    el_new = !st_new ? 20'h0_0000 : (el_sum[20] ? '1 : el_sum[19:0]);
    tr_new = st_new && (el_new >= w_r[2][`W2_DLY]); // see R9
  end

  // registers, stage state, counters and interrupt status
  always_comb begin
    enable_nxt  = enable_r;
    force_nxt   = force_r;
    fcnt_nxt    = fcnt_r;
    irq_msk_nxt = irq_msk_r;
    cfg_nxt     = cfg_r;
    scale_nxt   = scale_r;
    pick_nxt    = pick_r;
    scnt_nxt    = scnt_r;
    tcnt_nxt    = tcnt_r;
    el_nxt      = el_r;
    start_nxt   = start_r;
    trip_nxt    = trip_r;
    ev_set      = 16'h0000;
    w1c         = 16'h0000;
    if (force_r && tick_base) begin
      if (fcnt_r == 16'(FORCE_TICKS - 1)) begin
        force_nxt = 1'b0; // see R15
        fcnt_nxt  = 16'h0000;
      end else begin
        fcnt_nxt = fcnt_r + 16'h0001;
      end
    end
    if (wr && in_stage(ph_addr_r)) begin
      case (ph_addr_r[`STG_OFF])
        `O_CFG:    cfg_nxt[ws] = hwdata & `CFG_MASK;
        `O_SCALE:  scale_nxt[ws] = hwdata[15:0];
        `O_SCNT:   scnt_nxt[ws] = 16'h0000; // see R17
        `O_TCNT:   tcnt_nxt[ws] = 16'h0000; // see R17
        `O_STATUS: begin
          if (force_r) begin
            start_nxt[ws] = hwdata[`ST_START]; // see R14
            trip_nxt[ws]  = hwdata[`ST_TRIP];
          end
        end
        default: ;
      endcase
    end else if (wr) begin
      case (ph_addr_r)
        `A_ENABLE: enable_nxt = hwdata[NS-1:0]; // see R1
        `A_FORCE: begin
          force_nxt = hwdata[0]; // see R15
          fcnt_nxt  = 16'h0000;
        end
        `A_IRQ_ST:  w1c = hwdata[15:0];
        `A_IRQ_MSK: irq_msk_nxt = hwdata[15:0];
        default: ;
      endcase
    end
    // forced status is held; the engine resumes once force drops
    if (st_r == stage_pkg::e_eval && due_r[stg_r] && !force_r) begin
      start_nxt[stg_r] = st_new;
      trip_nxt[stg_r]  = tr_new; // see R9
      el_nxt[stg_r]    = el_new;
      pick_nxt[stg_r]  = w_r[1][`W1_PICK];
    end
    for (int s = 0; s < NS; s++) begin
      grp_nxt[s] = grp_sel(cfg_r[s]);
      if (!enable_r[s]) begin
        start_nxt[s] = 1'b0; // see R1
        trip_nxt[s]  = 1'b0;
        el_nxt[s]    = 20'h0_0000;
      end
      if (start_nxt[s] && !start_r[s]) begin
        ev_set[s] = 1'b1;
        if (scnt_nxt[s] != 16'hFFFF) begin
          scnt_nxt[s] = scnt_nxt[s] + 16'h0001; // see R17
        end
      end
      if (trip_nxt[s] && !trip_r[s]) begin
        ev_set[s + NS] = 1'b1;
        if (tcnt_nxt[s] != 16'hFFFF) begin
          tcnt_nxt[s] = tcnt_nxt[s] + 16'h0001; // see R17
        end
      end
    end
    irq_st_nxt = (irq_st_r & ~w1c) | ev_set;
    irq_nxt    = |(irq_st_nxt & irq_msk_nxt);
  end

  // register and stage state flip-flops
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      enable_r  <= '0;
      force_r   <= 1'b0;
      fcnt_r    <= 16'h0000;
      irq_st_r  <= 16'h0000;
      irq_msk_r <= 16'h0000;
      irq       <= 1'b0;
      start_r   <= '0;
      trip_r    <= '0;
      for (int s = 0; s < NS; s++) begin
        cfg_r[s]   <= `CFG_RST;
        scale_r[s] <= `SCALE_RST;
        pick_r[s]  <= 16'h0000;
        scnt_r[s]  <= 16'h0000;
        tcnt_r[s]  <= 16'h0000;
        el_r[s]    <= 20'h0_0000;
        grp_r[s]   <= 2'h0;
      end
    end else begin
      enable_r  <= enable_nxt;
      force_r   <= force_nxt;
      fcnt_r    <= fcnt_nxt;
      irq_st_r  <= irq_st_nxt;
      irq_msk_r <= irq_msk_nxt;
      irq       <= irq_nxt;
      start_r   <= start_nxt;
      trip_r    <= trip_nxt;
      cfg_r     <= cfg_nxt;
      scale_r   <= scale_nxt;
      pick_r    <= pick_nxt;
      scnt_r    <= scnt_nxt;
      tcnt_r    <= tcnt_nxt;
      el_r      <= el_nxt;
      grp_r     <= grp_nxt;
    end
  end

  // outputs straight from state flops
  assign stage_start  = start_r;
  assign stage_trip   = trip_r;
  assign force_active = force_r;
endmodule : programmable_protection_stage

// [stage_defs.svh]
// constants for the programmable protection stage bank
`ifndef STAGE_DEFS_SVH
`define STAGE_DEFS_SVH

`define NUM_STAGES   8
`define VAL_W        16
`define NUM_MEAS     59
`define NUM_VAI      5
`define MEM_AW       7
`define MEM_WORDS    128

// timing: clock rate and evaluation intervals
`define CLK_HZ       10000000
`define BASE_MS      10
`define MID_MS       20
`define SLOW_MS      100
`define BASE_CYCLES  (`CLK_HZ / 1000 * `BASE_MS)
`define MID_RATIO    (`MID_MS / `BASE_MS)
`define SLOW_RATIO   (`SLOW_MS / `BASE_MS)
`define DIV_W        17
`define FORCE_MIN    5
`define FORCE_TICKS  (`FORCE_MIN * 60 * 1000 / `BASE_MS)

// byte addresses, low 13 bits decoded
`define A_ENABLE     13'h0000
`define A_FORCE      13'h0004
`define A_IRQ_ST     13'h0008
`define A_IRQ_MSK    13'h000C
`define STG_SEL      12:8
`define STG_TAG      5'h01
`define STG_IDX      7:5
`define STG_OFF      4:0
`define O_CFG        5'h00
`define O_STATUS     5'h04
`define O_SCNT       5'h08
`define O_TCNT       5'h0C
`define O_PRIM       5'h10
`define O_SCALE      5'h14
`define MEM_SEL      12:9
`define MEM_TAG      4'h8
`define MEM_IDX      8:2

// fields of the per-stage config register
`define CFG_GRP      1:0
`define CFG_SRCK     6:4
`define CFG_SRCI     10:8
`define CFG_ALTG     13:12
`define CFG_IVAL     17:16
`define CFG_MASK     32'h0003_3773
`define CFG_RST      32'h0000_0000
`define SCALE_RST    16'h0100

// fields of the four setting words of a group
`define W0_SELA      5:0
`define W0_SELB      13:8
`define W0_MODE      17:16
`define W1_PICK      15:0
`define W2_DLY       19:0
`define W3_HYST      7:0
`define W3_FLOOR     31:16
`define HYST_MUL     36'h0_0000_028F
`define BAND_BITS    32:16
`define PRIM_BITS    31:8

// status register fields
`define ST_BLK       0
`define ST_START     1
`define ST_TRIP      2
`define ST_GRP       5:4

`endif

// [stage_pkg.sv]
// types shared by the programmable protection stage bank
package stage_pkg;
  typedef enum logic [1:0] {
    mode_over, mode_under, mode_diff, magnitude_gap_mode
  } cmp_mode_t;
  typedef enum logic [2:0] {
    src_none, src_digital, src_virtual, src_indicator, src_vout, src_fkey
  } grp_src_t;
  typedef enum logic [1:0] {e_idle, e_fetch, e_eval} eng_state_t;
endpackage : stage_pkg

// [setting_mem.sv]
// setting group memory with one write and two registered read ports
`timescale 1ns/100ps
`include "stage_defs.svh"
module setting_mem (
  input  logic                 sys_clk,
  input  logic                 rst,
  input  logic                 wr_en,
  input  logic [`MEM_AW-1:0]   wr_addr,
  input  logic [31:0]          wr_data,
  input  logic [`MEM_AW-1:0]   rd_addr_a,
  output logic [31:0]          rd_data_a,
  input  logic [`MEM_AW-1:0]   rd_addr_b,
  output logic [31:0]          rd_data_b
);
  logic [31:0] mem_r [`MEM_WORDS];

  // cleared at reset so no stage ever evaluates unknown settings
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `MEM_WORDS; i++) begin
        mem_r[i] <= 32'h0000_0000;
      end
      rd_data_a <= 32'h0000_0000;
      rd_data_b <= 32'h0000_0000;
    end else begin
      if (wr_en) begin
        mem_r[wr_addr] <= wr_data;
      end
      rd_data_a <= mem_r[rd_addr_a];
      rd_data_b <= mem_r[rd_addr_b];
    end
  end
endmodule : setting_mem

// [interval_tick.sv]
// base, mid and slow evaluation tick divider
`timescale 1ns/100ps
`include "stage_defs.svh"
module interval_tick #(
  parameter int BASE_CYCLES = `BASE_CYCLES
) (
  input  logic sys_clk,
  input  logic rst,
  output logic tick_base,
  output logic tick_mid,
  output logic tick_slow
);
  logic [`DIV_W-1:0] div_r, div_nxt;
  logic [3:0]        mid_r, mid_nxt, slow_r, slow_nxt;
  logic              base_nxt, midt_nxt, slowt_nxt, wrap;

  // mid and slow pulses coincide with a base pulse
  always_comb begin
    wrap      = (div_r == `DIV_W'(BASE_CYCLES - 1));
    div_nxt   = wrap ? '0 : div_r + `DIV_W'(1);
    mid_nxt   = mid_r;
    slow_nxt  = slow_r;
    base_nxt  = wrap;
    midt_nxt  = wrap && (mid_r == 4'h0);
    slowt_nxt = wrap && (slow_r == 4'h0);
    if (wrap) begin
      mid_nxt  = (mid_r == 4'(`MID_RATIO - 1)) ? 4'h0 : mid_r + 4'h1;
      slow_nxt = (slow_r == 4'(`SLOW_RATIO - 1)) ? 4'h0 : slow_r + 4'h1;
    end
  end

  // divider registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_r     <= '0;
      mid_r     <= 4'h0;
      slow_r    <= 4'h0;
      tick_base <= 1'b0;
      tick_mid  <= 1'b0;
      tick_slow <= 1'b0;
    end else begin
      div_r     <= div_nxt;
      mid_r     <= mid_nxt;
      slow_r    <= slow_nxt;
      tick_base <= base_nxt;
      tick_mid  <= midt_nxt;
      tick_slow <= slowt_nxt;
    end
  end
endmodule : interval_tick

// [stage_props.sv]
// checker of bus timing and stage outputs of the protection stage bank
`timescale 1ns/100ps
`include "stage_defs.svh"
module stage_props #(
  parameter int BASE_CYCLES = 20,
  parameter int FORCE_TICKS = 3
) (
  input logic                   sys_clk,
  input logic                   rst,
  input logic                   hsel,
  input logic [31:0]            haddr,
  input logic [1:0]             htrans,
  input logic                   hwrite,
  input logic                   hready,
  input logic [31:0]            hwdata,
  input logic                   hreadyout,
  input logic [31:0]            hrdata,
  input logic                   hresp,
  input logic [`NUM_STAGES-1:0] stage_start,
  input logic [`NUM_STAGES-1:0] stage_trip,
  input logic                   force_active
);
  // accepted transfer and edges where read data may move
  logic acc;
  logic rd_step;
  assign acc = hsel && htrans[1] && hready;
  assign rd_step = (acc && !hwrite) || !hreadyout;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  okay_resp_a: assert property (hresp == 1'b0) else $error("bad hresp");
  single_wait_a: assert property (!hreadyout |=> hreadyout)
    else $error("wait longer than one cycle");
  mem_wait_a: assert property (acc && !hwrite && haddr[12:9] == 4'h8
    |=> !hreadyout) else $error("memory read without wait");
  fast_answer_a: assert property (acc && (hwrite || haddr[12:9] != 4'h8)
    |=> hreadyout) else $error("unexpected wait");
  force_write_a: assert property (acc && hwrite && haddr[12:0] == 13'h0004
    |=> ##1 force_active == $past(hwdata[0])) else $error("force not set");
  read_hold_a: assert property ($changed(hrdata) |-> $past(rd_step))
    else $error("read data moved");
  force_freeze_a: assert property (force_active && $past(force_active) &&
    $past(force_active, 2) && !$past(hsel) && !$past(hsel, 2) &&
    !$past(hsel, 3) |-> $stable(stage_start) && $stable(stage_trip))
    else $error("stage moved under force");
  trip_needs_start_a: assert property ($rose(stage_trip[0]) &&
    !force_active |-> stage_start[0]) else $error("trip without start");
  reset_clear_a: assert property (disable iff (1'b0) rst |->
    stage_start == '0 && stage_trip == '0 && !force_active)
    else $error("outputs set in reset");
endmodule : stage_props
bind programmable_protection_stage stage_props #(
  .BASE_CYCLES(BASE_CYCLES), .FORCE_TICKS(FORCE_TICKS)
) stage_props_inst (
  .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .stage_start(stage_start), .stage_trip(stage_trip),
  .force_active(force_active)
);

// [testbench.sv]
// self-checking bench of the protection stage bank
`timescale 1ns/100ps
`include "stage_defs.svh"
module testbench;
  logic        sys_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic        force_active, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  din, vin, stage_start, stage_trip;
  logic [`NUM_MEAS*`VAL_W-1:0] meas;
  logic [`NUM_VAI*`VAL_W-1:0]  vai;
  int          bad_count, cmp_count;
  assign hready = hreadyout;
  programmable_protection_stage #(.BASE_CYCLES(100), .FORCE_TICKS(3))
    programmable_protection_stage_inst (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .meas_value(meas), .virtual_analog_inputs(vai), .digital_input_n(din),
    .virtual_input_n(vin), .indicator_signal_n(8'h00),
    .virtual_output_n(8'h00), .function_key_n(8'h00),
    .stage_start(stage_start), .stage_trip(stage_trip),
    .force_active(force_active), .irq(irq));
  // 10 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task stop_test;
    $display("mismatches %0d compares %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task hang;
    bad_count++;
    $display("unexpected at %0t: wait ran out", $time);
    stop_test();
  endtask : hang
  // one ahb-lite single transfer, read data left in rd
  task bus(input logic wr, input logic [12:0] a, input logic [31:0] wd);
    int n;
    hsel <= 1'b1;
    haddr <= {19'h0_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 20);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 40);
    rd = hrdata;
    if (n >= 40) hang();
  endtask : bus
  function logic [12:0] sa(input int s, input int o);
    return 13'(32'h100 + s * 32 + o);
  endfunction : sa
  function logic [12:0] ma(input int s, input int w);
    return 13'(32'h1000 + s * 64 + w * 4);
  endfunction : ma
  task setup(input int s, input logic [31:0] w0, w1, w2, w3);
    bus(1'b1, ma(s, 0), w0);
    bus(1'b1, ma(s, 1), w1);
    bus(1'b1, ma(s, 2), w2);
    bus(1'b1, ma(s, 3), w3);
  endtask : setup
  // bounded wait: kind 0 start, 1 trip, 2 force flag
  task wait_for(input int k, input int i, input logic v);
    int n;
    logic x;
    for (n = 0; n < 3000; n++) begin
      x = (k == 0) ? stage_start[i] : (k == 1) ? stage_trip[i] : force_active;
      if (x === v) break;
      @(posedge sys_clk);
    end
    if (n >= 3000) hang();
  endtask : wait_for
  // main sequence
  initial begin
    rst <= 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'h2; hwdata = '0; din = 8'h00; meas = '0;
    vin = '0;
    vai = '0;
    bad_count = 0; cmp_count = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    bus(1'b0, 13'h0000, 32'h0); check(rd, 32'h0);
    bus(1'b0, sa(0, 20), 32'h0); check(rd, 32'h0000_0100);
    bus(1'b1, 13'h0040, 32'hFFFF_FFFF);
    bus(1'b0, 13'h0040, 32'h0); check(rd, 32'h0);
    setup(0, 32'h0, 32'h0000_0100, 32'h0000_0014, 32'h0000_000A);
    setup(1, 32'h0001_003B, 32'h0000_0100, 32'h0000_03E8, 32'h0080_000A);
    bus(1'b0, ma(1, 0), 32'h0); check(rd, 32'h0001_003B);
    meas[15:0] <= 16'h0200;
    vai[15:0] <= 16'h0040;
    bus(1'b1, 13'h0000, 32'h0000_0003);
    wait_for(0, 0, 1'b1);
    check(32'(stage_trip[0]), 32'h0);
    check(32'(irq), 32'h0);
    wait_for(1, 0, 1'b1);
    bus(1'b0, sa(0, 8), 32'h0); check(rd, 32'h1);
    bus(1'b0, sa(0, 12), 32'h0); check(rd, 32'h1);
    bus(1'b0, sa(0, 16), 32'h0); check(rd, 32'h0000_0100);
    bus(1'b0, 13'h0008, 32'h0); check(rd, 32'h0000_0101);
    bus(1'b1, 13'h000C, 32'h0000_FFFF);
    repeat (2) @(posedge sys_clk);
    check(32'(irq), 32'h1);
    bus(1'b1, 13'h0008, 32'h0000_0101);
    repeat (2) @(posedge sys_clk);
    check(32'(irq), 32'h0);
    bus(1'b1, sa(0, 8), 32'h0);
    bus(1'b0, sa(0, 8), 32'h0); check(rd, 32'h0);
    meas[15:0] <= 16'h00F0;
    repeat (300) @(posedge sys_clk);
    check(32'(stage_start[0]), 32'h1);
    check(32'(stage_start[1]), 32'h0);
    meas[15:0] <= 16'h00D0;
    wait_for(0, 0, 1'b0);
    bus(1'b1, sa(1, 4), 32'h2);
    repeat (3) @(posedge sys_clk);
    check(32'(stage_start[1]), 32'h0);
    bus(1'b1, 13'h0004, 32'h1);
    bus(1'b1, sa(1, 4), 32'h2);
    repeat (3) @(posedge sys_clk);
    check(32'(force_active), 32'h1);
    check(32'(stage_start[1]), 32'h1);
    wait_for(2, 0, 1'b0);
    wait_for(0, 1, 1'b0);
    bus(1'b0, sa(1, 8), 32'h0); check(rd, 32'h1);
    vai[15:0] <= 16'h00C0;
    wait_for(0, 1, 1'b1);
    bus(1'b1, sa(0, 0), 32'h0000_2311);
    repeat (3) @(posedge sys_clk);
    bus(1'b0, sa(0, 4), 32'h0); check(32'(rd[5:4]), 32'h1);
    din <= 8'h08;
    repeat (3) @(posedge sys_clk);
    bus(1'b0, sa(0, 4), 32'h0); check(32'(rd[5:4]), 32'h2);
    din <= 8'h00;
    vin <= 8'h08;
    bus(1'b1, sa(0, 0), 32'h0000_2321);
    @(posedge sys_clk);
    bus(1'b0, sa(0, 4), 32'h0); check(32'(rd[5:4]), 32'h2);
    stop_test();
  end
endmodule : testbench
